/* rtl/pch_pkg.sv */
// constants shared by the user-side controller of the pci core and its data fifo
// assumes one clock domain, the pci clock, for everything
package pch_pkg;
    localparam int DATA_W = 32;
    localparam int CBE_W = 4;
    localparam int FIFO_DEPTH = 32;
    localparam int ONE_WORD = 1;
    localparam int TWO_WORDS = 2;
    localparam int HOLDOFF_MAX = 8;
    localparam logic [CBE_W-1:0] CBE_ALL_LANES = 4'h0;
    localparam logic IRQ_IDLE_N = 1'b1;
    localparam logic ABORT_UNUSED = 1'b0;

    typedef enum logic [3:0] {
        PCH_IDLE = 4'h1,
        PCH_REQ = 4'h2,
        PCH_DATA = 4'h4,
        PCH_FINISH = 4'h8
    } pch_state_t;
endpackage

/* rtl/pch_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module pch_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 32,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic ref_clk_i,         // clock
    input wire logic rst_b_i,           // sync reset, active low
    input wire logic in_valid_i,        // write request
    output logic in_ready_o,            // space available
    input wire logic [W-1:0] in_data_i, // write data
    output logic out_valid_o,           // word available
    input wire logic out_ready_i,       // pop
    output logic [W-1:0] out_data_o,    // head word
    output logic [AW:0] count_o         // words held
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic not_full;
    } pch_fifo_st_t;

    pch_fifo_st_t q, next_q;
    logic push, pop;

    always_comb begin
        next_q = q;
        push = in_valid_i && (q.cnt != (AW+1)'(DEPTH));
        pop = out_ready_i && (q.cnt != '0);
        if (push) begin
            next_q.mem[q.wp] = in_data_i;
            next_q.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
        end
        if (pop) begin
            next_q.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
        end
        next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // registered so that the space flag leaves the block from a flop
        next_q.not_full = (next_q.cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            q <= '0;
            q.not_full <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign in_ready_o = q.not_full;
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o = q.mem[q.rp];
    assign count_o = q.cnt;
endmodule
`default_nettype wire

/* rtl/pch_host.sv */
// user-side controller driving the back-end pins of a pci target/initiator core
// assumes the core runs on the same clock; its outputs are sampled without synchronisers
`timescale 1ns/1ps
`default_nettype none
module pch_host #(
    parameter int DATA_W = pch_pkg::DATA_W,
    parameter int FIFO_DEPTH = pch_pkg::FIFO_DEPTH,
    parameter int CW = $clog2(FIFO_DEPTH) + 1
) (
    input wire logic ref_clk_i,                                    // pci clock
    input wire logic rst_b_i,                                      // sync reset, active low
    input wire logic cmd_valid_i,                                  // start initiator transfer
    output logic cmd_ready_o,                                      // controller idle
    input wire logic cmd_write_i,                                  // 1 write, 0 read
    input wire logic [pch_pkg::CBE_W-1:0] cmd_code_i,              // bus command
    input wire logic [DATA_W-1:0] cmd_addr_i,                      // start address
    input wire logic [CW-1:0] cmd_words_i,                         // words, 0 taken as 1
    input wire logic wr_valid_i,                                   // write data valid
    output logic wr_ready_o,                                       // fifo space
    input wire logic [DATA_W-1:0] wr_data_i,                       // write data
    output logic rd_valid_o,                                       // read word pulse
    output logic [DATA_W-1:0] rd_data_o,                           // read word
    output logic xfer_done_o,                                      // transfer end pulse
    output logic xfer_early_o,                                     // ended before all words
    output logic xfer_timeout_o,                                   // timeout seen in transfer
    input wire logic irq_req_i,                                    // interrupt request level
    input wire logic isolate_req_i,                                // keep core off the bus
    input wire logic tgt_retry_i,                                  // retry target accesses
    input wire logic tgt_disconnect_i,                             // disconnect target access
    input wire logic tgt_data_avail_i,                             // target data on hand
    output logic user_ready_o,                                     // to core ready
    output logic user_terminate_o,                                 // to core terminate
    output logic user_target_abort_o,                              // to core target abort
    output logic user_irq_n_o,                                     // to core irq, low active
    output logic internal_bus_isolate_o,                           // to core keep-out
    output logic bus_request_o,                                    // to core request
    output logic [pch_pkg::CBE_W-1:0] initiator_cmd_byte_en_o,     // to core cmd/be
    output logic initiator_direction_o,                            // to core direction
    output logic complete_o,                                       // to core complete
    output logic [DATA_W-1:0] internal_ad_bus_o,                   // ad bus drive value
    output logic internal_ad_bus_oe_o,                             // ad bus drive enable
    input wire logic [DATA_W-1:0] internal_ad_bus_i,               // ad bus level
    input wire logic init_addr_n_i,                                // core address state, low
    input wire logic init_data_i,                                  // core initiator data state
    input wire logic transfer_done_pulse_i,                        // core data valid
    input wire logic source_advance_strobe_i,                      // core source enable
    input wire logic timeout_i                                     // core latency timeout
);
    import pch_pkg::*;

    typedef struct packed {
        pch_state_t st;
        logic cmd_ready;
        logic write;
        logic [CBE_W-1:0] cmd;
        logic [CW-1:0] words;
        logic [CW-1:0] done_cnt;
        logic [CW-1:0] load_cnt;
        logic seen_data;
        logic tmo;
        logic request;
        logic [CBE_W-1:0] cbe;
        logic dir;
        logic complete;
        logic [DATA_W-1:0] ad_out;
        logic ad_oe;
        logic [DATA_W-1:0] rd_data;
        logic rd_valid;
        logic done;
        logic early;
        logic tmo_out;
        logic ready;
        logic term;
        logic isolate;
        logic irq_n;
        logic abort;
    } pch_host_st_t;

    pch_host_st_t q, next_q;
    logic fifo_pop, fifo_valid;
    logic [DATA_W-1:0] fifo_data;
    logic [CW-1:0] fifo_count;
    logic [CW-1:0] req_words;

    pch_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(wr_valid_i),
        .in_ready_o(wr_ready_o),
        .in_data_i(wr_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data),
        .count_o(fifo_count)
    );

    always_comb begin
        next_q = q;
        fifo_pop = 1'b0;
        req_words = (cmd_words_i == '0) ? CW'(ONE_WORD) : cmd_words_i;
        next_q.rd_valid = 1'b0;
        next_q.done = 1'b0;
        next_q.early = 1'b0;
        next_q.tmo_out = 1'b0;
        // target side answers
        next_q.isolate = isolate_req_i;
        next_q.term = isolate_req_i || tgt_retry_i || tgt_disconnect_i;
        if (isolate_req_i || tgt_retry_i) begin
            next_q.ready = 1'b0;
        end else if (tgt_disconnect_i) begin
            next_q.ready = tgt_data_avail_i;
        end else begin
            next_q.ready = 1'b1;
        end
        next_q.irq_n = ~irq_req_i;
        next_q.abort = ABORT_UNUSED;
        unique case (q.st)
            PCH_IDLE: begin
                // write waits until the whole burst sits in the fifo
                if (cmd_valid_i && (!cmd_write_i || fifo_count >= req_words)) begin
                    next_q.st = PCH_REQ;
                    next_q.cmd_ready = 1'b0;
                    next_q.write = cmd_write_i;
                    next_q.cmd = cmd_code_i;
                    next_q.words = req_words;
                    next_q.done_cnt = '0;
                    next_q.load_cnt = '0;
                    next_q.seen_data = 1'b0;
                    next_q.tmo = 1'b0;
                    next_q.request = 1'b1;
                    next_q.cbe = cmd_code_i;
                    next_q.dir = cmd_write_i;
                    next_q.complete = (req_words == CW'(ONE_WORD));
                    next_q.ad_out = cmd_addr_i;
                    next_q.ad_oe = 1'b1;
                end
            end
            PCH_REQ: begin
                if (!init_addr_n_i) begin
                    next_q.st = PCH_DATA;
                    next_q.request = 1'b0;
                    next_q.cbe = CBE_ALL_LANES;
                    next_q.complete = q.complete || (q.words <= CW'(TWO_WORDS));
                    next_q.ad_oe = q.write;
                    if (q.write) begin
                        next_q.ad_out = fifo_data;
                        next_q.load_cnt = CW'(ONE_WORD);
                        fifo_pop = 1'b1;
                    end
                end
            end
            PCH_DATA: begin
                if (init_data_i) begin
                    next_q.seen_data = 1'b1;
                end
                if (timeout_i) begin
                    next_q.tmo = 1'b1;
                end
                if (transfer_done_pulse_i) begin
                    next_q.done_cnt = q.done_cnt + CW'(ONE_WORD);
                    next_q.rd_valid = !q.write;
                    next_q.rd_data = internal_ad_bus_i;
                end
                if (next_q.done_cnt + CW'(TWO_WORDS) >= q.words) begin
                    next_q.complete = 1'b1;
                end
                if (q.write && source_advance_strobe_i && q.load_cnt < q.words && fifo_valid) begin
                    next_q.ad_out = fifo_data;
                    next_q.load_cnt = q.load_cnt + CW'(ONE_WORD);
                    fifo_pop = 1'b1;
                end
                if (q.seen_data && !init_data_i) begin
                    next_q.st = PCH_FINISH;
                    next_q.complete = 1'b0;
                    next_q.ad_oe = 1'b0;
                end
            end
            PCH_FINISH: begin
                next_q.st = PCH_IDLE;
                next_q.cmd_ready = 1'b1;
                next_q.done = 1'b1;
                next_q.early = (q.done_cnt < q.words);
                next_q.tmo_out = q.tmo;
                // drain unsent words of a cut-short write
                fifo_pop = q.write && (q.load_cnt < q.words) && fifo_valid;
                if (fifo_pop) begin
                    next_q.load_cnt = q.load_cnt + CW'(ONE_WORD);
                    next_q.st = PCH_FINISH;
                    next_q.cmd_ready = 1'b0;
                    next_q.done = 1'b0;
                    next_q.early = 1'b0;
                    next_q.tmo_out = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            q <= '0;
            q.st <= PCH_IDLE;
            q.cmd_ready <= 1'b1;
            q.ready <= 1'b1;
            q.irq_n <= IRQ_IDLE_N;
            q.abort <= ABORT_UNUSED;
        end else begin
            q <= next_q;
        end
    end

    assign cmd_ready_o = q.cmd_ready;
    assign rd_valid_o = q.rd_valid;
    assign rd_data_o = q.rd_data;
    assign xfer_done_o = q.done;
    assign xfer_early_o = q.early;
    assign xfer_timeout_o = q.tmo_out;
    assign user_ready_o = q.ready;
    assign user_terminate_o = q.term;
    assign user_target_abort_o = q.abort;
    assign user_irq_n_o = q.irq_n;
    assign internal_bus_isolate_o = q.isolate;
    assign bus_request_o = q.request;
    assign initiator_cmd_byte_en_o = q.cbe;
    assign initiator_direction_o = q.dir;
    assign complete_o = q.complete;
    assign internal_ad_bus_o = q.ad_out;
    assign internal_ad_bus_oe_o = q.ad_oe;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    logic [3:0] holdoff_cnt;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || user_ready_o || user_terminate_o) begin
            holdoff_cnt <= '0;
        end else if (holdoff_cnt != 4'hf) begin
            holdoff_cnt <= holdoff_cnt + 4'h1;
        end
    end

    a_ready_holdoff: assert property (holdoff_cnt <= 4'(HOLDOFF_MAX))
        else $error("ready held off too long");
    a_retry_answer: assert property (tgt_retry_i && !tgt_disconnect_i |=>
        user_terminate_o && !user_ready_o)
        else $error("retry not signalled");
    a_disc_answer: assert property (tgt_disconnect_i && !tgt_retry_i && !isolate_req_i |=>
        user_terminate_o && user_ready_o == $past(tgt_data_avail_i))
        else $error("disconnect not signalled");
    a_abort_low: assert property (!user_target_abort_o)
        else $error("target abort driven");
    a_internal_bus_isolate_retry: assert property (internal_bus_isolate_o |->
        user_terminate_o && !user_ready_o)
        else $error("isolate without retry");
    a_request_hold: assert property ($fell(bus_request_o) |-> $past(!init_addr_n_i))
        else $error("request dropped before address");
    a_cmd_addr: assert property ($rose(bus_request_o) |->
        initiator_cmd_byte_en_o == $past(cmd_code_i)
        && initiator_direction_o == $past(cmd_write_i))
        else $error("command or direction wrong");
    a_be_zero: assert property (init_data_i |->
        initiator_cmd_byte_en_o == CBE_ALL_LANES)
        else $error("byte enables not zero");
    a_single_complete: assert property ($rose(bus_request_o) && q.words == CW'(ONE_WORD)
        |-> complete_o)
        else $error("single transfer without complete");
    a_complete_held: assert property ($fell(complete_o) |->
        q.st == PCH_FINISH && $past(!init_data_i))
        else $error("complete dropped in data state");

    c_write_done: cover property (xfer_done_o && q.write && !xfer_early_o);
    c_read_done: cover property (xfer_done_o && !q.write);
    c_retry: cover property (user_terminate_o && !user_ready_o && !internal_bus_isolate_o);
    c_internal_bus_isolate: cover property (internal_bus_isolate_o);
endmodule
`default_nettype wire

/* tb/pch_core_model.sv */
// behavioural stand-in for the pci core back end that the controller drives
// assumes the controller's outputs are registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module pch_core_model (
    input wire logic ref_clk_i,        // pci clock
    input wire logic rst_b_i,          // sync reset, active low
    input wire logic master_set_i,     // software sets bus master enable
    input wire logic gnt_i,            // arbiter grant
    input wire logic stall_i,          // target wait state
    input wire logic [7:0] lat_val_i,  // latency timer value
    input wire logic user_ready_i,     // ready from controller
    input wire logic user_irq_n_i,     // irq from controller
    input wire logic isolate_i,        // keep-out from controller
    input wire logic bus_request_i,    // request from controller
    input wire logic direction_i,      // 1 write
    input wire logic complete_i,       // finish request
    input wire logic [31:0] ad_drv_i,  // controller ad value
    input wire logic ad_oe_i,          // controller ad enable
    output logic [31:0] ad_lvl_o,      // resolved ad bus
    output logic addr_n_o,             // address state, low
    output logic data_o,               // initiator data state
    output logic done_o,               // data valid pulse
    output logic src_adv_o,            // source advance strobe
    output logic timeout_o,            // latency timeout
    output logic irq_pin_o,            // bus interrupt, high = asserted
    output logic wr_seen_o,            // write word taken
    output logic [31:0] wr_word_o      // write word
);
    logic mst, prev, fin, rd, st;
    logic [7:0] cnt;
    logic [5:0] idx;
    logic [31:0] last, rdw, base;
    logic xfer;
    assign addr_n_o = !(!st && bus_request_i && mst && gnt_i);
    assign data_o = st;
    // prev gives the idle ready cycle after every transfer
    assign xfer = st && user_ready_i && !prev && !stall_i;
    assign src_adv_o = xfer && !rd;
    assign timeout_o = st && cnt >= lat_val_i;
    assign irq_pin_o = !user_irq_n_i;
    // released bus shows the inverse of its last level, or the read word in a read data-valid cycle while keep-out is low
    assign ad_lvl_o = ad_oe_i ? ad_drv_i : (done_o && rd && !isolate_i) ? rdw : ~last;
    always_ff @(posedge ref_clk_i) begin
        last <= ad_lvl_o;
        prev <= xfer;
        done_o <= xfer;
        wr_seen_o <= xfer && !rd;
        wr_word_o <= ad_lvl_o;
        if (cnt != 8'hff) cnt <= cnt + 8'h01;
        if (master_set_i) mst <= 1'b1;
        if (!addr_n_o) begin
            st <= 1'b1;
            base <= ad_lvl_o;
            rd <= !direction_i;
            fin <= complete_i;
            cnt <= 8'h00;
            idx <= 6'h00;
        end
        if (xfer) begin
            rdw <= base + {24'h0, idx, 2'b00};
            idx <= idx + 6'h01;
            if (fin) st <= 1'b0;
            else if (complete_i || (timeout_o && !gnt_i)) fin <= 1'b1;
        end
        if (!rst_b_i) begin
            st <= 1'b0;
            mst <= 1'b0;
            prev <= 1'b0;
            done_o <= 1'b0;
            wr_seen_o <= 1'b0;
            fin <= 1'b0;
            rd <= 1'b0;
            cnt <= 8'h00;
            last <= 32'h0;
        end
    end
endmodule
`default_nettype wire

/* tb/test_pci_core_user_side_handshake.sv */
// self-checking bench for the user-side controller against a core model
// assumes the core model answers on the same clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module test_pci_core_user_side_handshake;
    import pch_pkg::*;
    logic ref_clk_i = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, wr_valid = 1'b0;
    logic irq_req = 1'b0, iso = 1'b0, retry = 1'b0, disc = 1'b0, avail = 1'b0;
    logic mst_set = 1'b0, gnt = 1'b1, stall = 1'b0;
    logic [3:0] cmd_code = 4'h0;
    logic [5:0] cmd_words = 6'h01;
    logic [7:0] lat = 8'hff;
    logic [31:0] cmd_addr = 32'h0, wr_data = 32'h0;
    logic cmd_ready, wr_ready, rd_valid, done, early, tmo, u_ready, u_term, u_abort, u_irq_n;
    logic u_iso, req, dir, cmpl, ad_oe, addr_n, mdata, mdone, src, mtmo, irq_pin, wr_seen;
    logic [3:0] cbe;
    logic [31:0] rd_data, ad_o, ad_lvl, wr_word;
    logic [31:0] q[$];
    int seed = 32'h2b2eaf35;
    int err_count = 0;
    int n_checks = 0;
    pch_host pch_host_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write), .cmd_code_i(cmd_code),
        .cmd_addr_i(cmd_addr), .cmd_words_i(cmd_words), .wr_valid_i(wr_valid),
        .wr_ready_o(wr_ready), .wr_data_i(wr_data), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
        .xfer_done_o(done), .xfer_early_o(early), .xfer_timeout_o(tmo), .irq_req_i(irq_req),
        .isolate_req_i(iso), .tgt_retry_i(retry), .tgt_disconnect_i(disc),
        .tgt_data_avail_i(avail), .user_ready_o(u_ready), .user_terminate_o(u_term),
        .user_target_abort_o(u_abort), .user_irq_n_o(u_irq_n), .internal_bus_isolate_o(u_iso),
        .bus_request_o(req), .initiator_cmd_byte_en_o(cbe), .initiator_direction_o(dir),
        .complete_o(cmpl), .internal_ad_bus_o(ad_o), .internal_ad_bus_oe_o(ad_oe),
        .internal_ad_bus_i(ad_lvl), .init_addr_n_i(addr_n), .init_data_i(mdata),
        .transfer_done_pulse_i(mdone), .source_advance_strobe_i(src), .timeout_i(mtmo));
    pch_core_model pch_core_model_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b),
        .master_set_i(mst_set), .gnt_i(gnt), .stall_i(stall), .lat_val_i(lat),
        .user_ready_i(u_ready), .user_irq_n_i(u_irq_n), .isolate_i(u_iso), .bus_request_i(req),
        .direction_i(dir), .complete_i(cmpl), .ad_drv_i(ad_o), .ad_oe_i(ad_oe),
        .ad_lvl_o(ad_lvl), .addr_n_o(addr_n), .data_o(mdata), .done_o(mdone), .src_adv_o(src),
        .timeout_o(mtmo), .irq_pin_o(irq_pin), .wr_seen_o(wr_seen), .wr_word_o(wr_word));
    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // expected {terminate, ready} from {irq, isolate, retry, disconnect, avail}
    function automatic logic [1:0] exp_ctl(input logic [4:0] p);
        return {p[3] | p[2] | p[1], !(p[3] | p[2]) && (!p[1] || p[0])};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic push(input int n);
        logic [31:0] d;
        for (int k = 0; k < n; k++) begin
            d = $random(seed);
            wr_valid <= 1'b1;
            wr_data <= d;
            q.push_back(d);
            @(posedge ref_clk_i);
            while (!wr_ready) @(posedge ref_clk_i);
        end
        wr_valid <= 1'b0;
    endtask
    task automatic run_xfer(input logic wr, input int words, late, lat_v,
                            input logic dropg, exp_e, exp_t, hold);
        logic [31:0] a, e;
        logic [3:0] c;
        int nrd, nwr;
        a = $random(seed) & 32'hfffffffc;
        c = 4'($random(seed));
        nrd = 0;
        nwr = 0;
        q.delete();
        gnt <= 1'b1;
        lat <= 8'(lat_v);
        if (wr) push(words - late);
        if (wr && words == FIFO_DEPTH) begin
            @(posedge ref_clk_i);
            `CHK("fifo full", 1'b0, wr_ready)
        end
        cmd_write <= wr;
        cmd_code <= c;
        cmd_addr <= a;
        cmd_words <= 6'(words);
        cmd_valid <= 1'b1;
        if (late > 0) begin
            repeat (10) @(posedge ref_clk_i);
            `CHK("refused idle", 1'b1, cmd_ready)
            `CHK("refused request", 1'b0, req)
            push(late);
        end
        for (int i = 0; i < 3000; i++) begin
            @(posedge ref_clk_i);
            if (!cmd_ready) cmd_valid <= 1'b0;
            stall <= 2'($random(seed)) == 2'h0;
            retry <= 3'($random(seed)) == 3'h0;
            if (mdata && dropg) gnt <= 1'b0;
            if (hold && i == 8) begin
                `CHK("request held", 1'b1, req)
                mst_set <= 1'b1;
            end
            if (!addr_n) begin
                `CHK("command", c, cbe)
                `CHK("direction", wr, dir)
                `CHK("address", a, ad_lvl)
                `CHK("complete", 1'(words == 1), cmpl)
            end
            if (mdata) `CHK("byte enables", CBE_ALL_LANES, cbe)
            if (rd_valid) begin
                `CHK("read word", a + 32'(nrd * 4), rd_data)
                nrd++;
            end
            if (wr_seen) begin
                e = q.size() > 0 ? q.pop_front() : 32'hx;
                `CHK("write word", e, wr_word)
                nwr++;
            end
            if (done) break;
        end
        `CHK("done", 1'b1, done)
        `CHK("early", exp_e, early)
        `CHK("timeout", exp_t, tmo)
        `CHK("idle again", 1'b1, cmd_ready)
        if (!exp_e) `CHK("word count", words, wr ? nwr : nrd)
        $display("test done: write %0d words %0d", wr, words);
    endtask
    initial begin
        logic [4:0] p1, p2, p;
        repeat (16) @(posedge ref_clk_i);
        rst_b <= 1'b1;
        @(posedge ref_clk_i);
        `CHK("reset idle", 1'b1, cmd_ready)
        `CHK("reset ready", 1'b1, u_ready)
        `CHK("reset irq", 1'b1, u_irq_n)
        `CHK("reset request", 1'b0, req)
        run_xfer(1'b0, 1, 0, 255, 1'b0, 1'b0, 1'b0, 1'b1);
        run_xfer(1'b1, FIFO_DEPTH, 0, 255, 1'b0, 1'b0, 1'b0, 1'b0);
        run_xfer(1'b1, 4, 2, 255, 1'b0, 1'b0, 1'b0, 1'b0);
        run_xfer(1'b0, 2, 0, 255, 1'b0, 1'b0, 1'b0, 1'b0);
        for (int t = 0; t < 10; t++) begin
            run_xfer(1'($random(seed)), 1 + ($random(seed) & 7), 0, 255, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        run_xfer(1'b0, 3, 0, 0, 1'b0, 1'b0, 1'b1, 1'b0);
        run_xfer(1'b1, 8, 0, 0, 1'b1, 1'b1, 1'b1, 1'b0);
        run_xfer(1'b0, 8, 0, 0, 1'b1, 1'b1, 1'b1, 1'b0);
        p1 = 5'h0;
        p2 = 5'h0;
        for (int i = 0; i < 200; i++) begin
            @(posedge ref_clk_i);
            if (i > 1) begin
                `CHK("target ctl", exp_ctl(p2), {u_term, u_ready})
                `CHK("keep-out", p2[3], u_iso)
                `CHK("irq", !p2[4], u_irq_n)
                `CHK("irq pin", p2[4], irq_pin)
                `CHK("abort", 1'b0, u_abort)
            end
            p = 5'($random(seed));
            {irq_req, iso, retry, disc, avail} <= p;
            p2 = p1;
            p1 = p;
        end
        $display("test done: target controls");
        report_and_stop;
    end
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        err_count++;
        report_and_stop;
    end
endmodule
`default_nettype wire
